// >>> hdl/fpuir_fmt.sv
// Per-format packing of an unbounded-exponent rounded result.
// Combinational; the top instantiates it once per precision.
`timescale 1ns/1ps
module fpuir_fmt
#(
  parameter int EXP_W  = 8,
  parameter int FRAC_W = 23,
  parameter int BIAS   = 127,
  parameter int SCALE  = 192
)
(
  sign,
  exp_in,
  frac_in,
  is_zero,
  rnd_mode,
  tiny,
  huge,
  plain_word,
  uf_scaled,
  of_scaled,
  of_masked
);
  import fpuir_pkg::*;
  input  wire logic               sign;
  input  wire logic signed [15:0] exp_in;
  input  wire logic [51:0]        frac_in;
  input  wire logic               is_zero;
  input  wire logic [1:0]         rnd_mode;
  output logic                    tiny;
  output logic                    huge;
  output logic [63:0]             plain_word;
  output logic [63:0]             uf_scaled;
  output logic [63:0]             of_scaled;
  output logic [63:0]             of_masked;

  localparam int WW = 1 + EXP_W + FRAC_W;
  localparam logic signed [15:0] B_S    = 16'(BIAS);
  localparam logic signed [15:0] SC_S   = 16'(SCALE);
  localparam logic signed [15:0] MIN_E  = 16'(1 - BIAS);
  localparam logic [EXP_W-1:0]   E_ONES = '1;
  localparam logic [EXP_W-1:0]   E_MAX  = E_ONES - 1'b1;

  logic [FRAC_W-1:0] frac;     // Fraction at this precision
  logic signed [15:0] e_plain; // Biased exponent, bounded range
  logic signed [15:0] e_up;    // Biased exponent after upscaling
  logic signed [15:0] e_dn;    // Biased exponent after downscaling
  logic [WW-1:0]     inf_w;    // Signed infinity
  logic [WW-1:0]     max_w;    // Signed largest finite value
  logic              to_inf;   // Masked overflow rounds to infinity

  assign frac    = frac_in[51 -: FRAC_W];
  assign e_plain = exp_in + B_S;
  assign e_up    = exp_in + SC_S + B_S;
  assign e_dn    = exp_in - SC_S + B_S;

  // Tiny after rounding with unbounded exponent; huge past max finite
  assign tiny = !is_zero && (exp_in < MIN_E);   // [RULE_01] [RULE_02]
  assign huge = !is_zero && (exp_in > B_S);

  assign plain_word = 64'({sign, is_zero ? {EXP_W{1'b0}} : e_plain[EXP_W-1:0],
                           frac});
  // Underflow trap result scaled up by two to the SCALE
  assign uf_scaled  = 64'({sign, e_up[EXP_W-1:0], frac});       // [RULE_06]
  assign of_scaled  = 64'({sign, e_dn[EXP_W-1:0], frac});

  assign inf_w = {sign, E_ONES, {FRAC_W{1'b0}}};
  assign max_w = {sign, E_MAX, {FRAC_W{1'b1}}};

  // Direction of masked overflow per rounding mode and sign
  always_comb
  begin
    case (rnd_mode)
      RND_NEAREST: to_inf = 1'b1;                              // [RULE_15]
      RND_DOWN:    to_inf = sign;
      RND_UP:      to_inf = !sign;
      RND_ZERO:    to_inf = 1'b0;
      default:     to_inf = 1'b1;
    endcase
  end

  assign of_masked = 64'(to_inf ? inf_w : max_w);

endmodule

// >>> hdl/fpuir_pkg.sv
// Package for the floating-point underflow and inexact response block.
// Holds register offsets, field positions, reset values and format data.
// Assumes a 32-bit AXI4-Lite register bus with byte addressing.
package fpuir_pkg;

  // Register bus widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFF   = 8'h00;
  localparam logic [7:0] STATUS_OFF = 8'h04;
  localparam logic [7:0] IMASK_OFF  = 8'h08;
  localparam logic [7:0] RES_LO_OFF = 8'h0c;
  localparam logic [7:0] RES_HI_OFF = 8'h10;

  // Control fields: exception masks and rounding mode
  localparam int UF_MASK_BIT = 0;
  localparam int PE_MASK_BIT = 1;
  localparam int OF_MASK_BIT = 2;
  localparam int RND_LSB     = 3;
  localparam int CTRL_W      = 5;
  localparam logic [4:0] CTRL_RESET = 5'h07;

  // Status and interrupt mask fields (same layout)
  localparam int UF_BIT  = 0;
  localparam int PE_BIT  = 1;
  localparam int OF_BIT  = 2;
  localparam int EXC_BIT = 3;
  localparam int STAT_W  = 4;
  localparam logic [3:0] STATUS_RESET = 4'h0;
  localparam logic [3:0] IMASK_RESET  = 4'h0;

  // Rounding mode encodings
  localparam logic [1:0] RND_NEAREST = 2'h0;
  localparam logic [1:0] RND_DOWN    = 2'h1;
  localparam logic [1:0] RND_UP      = 2'h2;
  localparam logic [1:0] RND_ZERO    = 2'h3;

  // Bus responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Floating-point formats and scale factors for trapped results
  localparam int SGL_EXP_W  = 8;
  localparam int SGL_FRAC_W = 23;
  localparam int SGL_BIAS   = 127;
  localparam int SGL_SCALE  = 192;
  localparam int DBL_EXP_W  = 11;
  localparam int DBL_FRAC_W = 52;
  localparam int DBL_BIAS   = 1023;
  localparam int DBL_SCALE  = 1536;

  // Operation class of the incoming result
  typedef enum logic [3:0] {
    OP_ADD, OP_SUB, OP_ADDSUB, OP_HADD, OP_HSUB,
    OP_MUL, OP_DIV, OP_SQRT, OP_NARROW, OP_INT_CONV
  } fpuir_op_type;

endpackage

// >>> hdl/fpuir_top.sv
// Floating-point underflow / inexact response unit with AXI4-Lite regs.
// Assumes an upstream rounder supplies the unbounded-exponent result and
// the bounded (denormalised) result, one operation per op_valid cycle.
//
// Functional notes
// [RULE_01] Single underflow: rounded result below min normal
// [RULE_02] Double underflow: rounded result below min normal
// [RULE_03] Underflow for arithmetic and narrowing, not sqrt
// [RULE_04] Masked single underflow: bounded result, flags if inexact
// [RULE_05] Masked double underflow: bounded result, flags if inexact
// [RULE_06] Unmasked underflow: scale up by 2^192 or 2^1536
// [RULE_07] Unmasked underflow: underflow always, inexact if inexact
// [RULE_08] Inexact raised whenever result not exactly representable
// [RULE_09] Masked inexact: bounded rounded result, inexact flag set
// [RULE_10] Inexact may join masked underflow or overflow
// [RULE_11] Unmasked inexact only without unmasked under/overflow
// [RULE_12] With masked overflow: overflow flag, masked overflow result
// [RULE_13] With masked underflow: underflow flag, masked underflow result
// [RULE_14] Otherwise bounded rounded result and inexact flag
// [RULE_15] Masked overflow, nearest: signed infinity, overflow+inexact
// [RULE_16] Mask bits pick response; unmasked signals exception
// [RULE_17] Status flags stay set until software clears
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module fpuir_top
(
  ref_clk,
  rstn,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  op_valid,
  op_double,
  op_kind,
  op_sign,
  op_exp,
  op_frac,
  op_zero,
  op_inexact,
  op_bounded,
  op_bounded_inexact,
  res_valid,
  res_data,
  res_underflow,
  res_inexact,
  res_overflow,
  fp_exception,
  irq
);
  import fpuir_pkg::*;
  input  wire logic                   ref_clk;
  input  wire logic                   rstn;
  input  wire logic [7:0]             s_axi_awaddr;
  input  wire logic                   s_axi_awvalid;
  output logic                        s_axi_awready;
  input  wire logic [31:0]            s_axi_wdata;
  input  wire logic [3:0]             s_axi_wstrb;
  input  wire logic                   s_axi_wvalid;
  output logic                        s_axi_wready;
  output logic [1:0]                  s_axi_bresp;
  output logic                        s_axi_bvalid;
  input  wire logic                   s_axi_bready;
  input  wire logic [7:0]             s_axi_araddr;
  input  wire logic                   s_axi_arvalid;
  output logic                        s_axi_arready;
  output logic [31:0]                 s_axi_rdata;
  output logic [1:0]                  s_axi_rresp;
  output logic                        s_axi_rvalid;
  input  wire logic                   s_axi_rready;
  input  wire logic                   op_valid;
  input  wire logic                   op_double;
  input  wire fpuir_pkg::fpuir_op_type op_kind;
  input  wire logic                   op_sign;
  input  wire logic signed [15:0]     op_exp;
  input  wire logic [51:0]            op_frac;
  input  wire logic                   op_zero;
  input  wire logic                   op_inexact;
  input  wire logic [63:0]            op_bounded;
  input  wire logic                   op_bounded_inexact;
  output logic                        res_valid;
  output logic [63:0]                 res_data;
  output logic                        res_underflow;
  output logic                        res_inexact;
  output logic                        res_overflow;
  output logic                        fp_exception;
  output logic                        irq;

  // Register state
  logic [CTRL_W-1:0] ctrl_reg, ctrl_next;       // Masks and rounding
  logic [STAT_W-1:0] status_reg, status_next;   // Sticky flags
  logic [STAT_W-1:0] imask_reg, imask_next;     // Interrupt enables
  logic              irq_reg, irq_next;         // Interrupt level
  // Bus slave state
  logic              aw_got_reg, aw_got_next;   // Write address held
  logic              w_got_reg, w_got_next;     // Write data held
  logic [7:0]        awaddr_reg, awaddr_next;
  logic [31:0]       wdata_reg, wdata_next;
  logic [3:0]        wstrb_reg, wstrb_next;
  logic              awready_reg, awready_next;
  logic              wready_reg, wready_next;
  logic              bvalid_reg, bvalid_next;
  logic [1:0]        bresp_reg, bresp_next;
  logic              arready_reg, arready_next;
  logic              rvalid_reg, rvalid_next;
  logic [31:0]       rdata_reg, rdata_next;
  logic [1:0]        rresp_reg, rresp_next;
  // Result stage state
  logic              rv_reg, rv_next;
  logic [63:0]       rd_reg, rd_next;
  logic              ruf_reg, ruf_next;
  logic              rpe_reg, rpe_next;
  logic              rof_reg, rof_next;
  logic              rexc_reg, rexc_next;

  // Format unit outputs
  logic        s_tiny, s_huge, d_tiny, d_huge;
  logic [63:0] s_plain, s_ufs, s_ofs, s_ofm;
  logic [63:0] d_plain, d_ufs, d_ofs, d_ofm;

  // Single precision packing
  fpuir_fmt #(.EXP_W(SGL_EXP_W), .FRAC_W(SGL_FRAC_W),
              .BIAS(SGL_BIAS), .SCALE(SGL_SCALE)) u_sgl
  (
    .sign       (op_sign),
    .exp_in     (op_exp),
    .frac_in    (op_frac),
    .is_zero    (op_zero),
    .rnd_mode   (ctrl_reg[RND_LSB +: 2]),
    .tiny       (s_tiny),
    .huge       (s_huge),
    .plain_word (s_plain),
    .uf_scaled  (s_ufs),
    .of_scaled  (s_ofs),
    .of_masked  (s_ofm)
  );

  // Double precision packing
  fpuir_fmt #(.EXP_W(DBL_EXP_W), .FRAC_W(DBL_FRAC_W),
              .BIAS(DBL_BIAS), .SCALE(DBL_SCALE)) u_dbl
  (
    .sign       (op_sign),
    .exp_in     (op_exp),
    .frac_in    (op_frac),
    .is_zero    (op_zero),
    .rnd_mode   (ctrl_reg[RND_LSB +: 2]),
    .tiny       (d_tiny),
    .huge       (d_huge),
    .plain_word (d_plain),
    .uf_scaled  (d_ufs),
    .of_scaled  (d_ofs),
    .of_masked  (d_ofm)
  );

  // Response selection for one operation
  logic uf_cond, of_cond, uf_m, of_m, pe_m, uf_ok, is_int;
  always_comb
  begin
    is_int  = (op_kind == OP_INT_CONV);
    uf_ok   = (op_kind != OP_SQRT) && !is_int;                // [RULE_03]
    uf_cond = uf_ok && (op_double ? d_tiny : s_tiny);
    of_cond = !is_int && (op_double ? d_huge : s_huge);
    uf_m    = ctrl_reg[UF_MASK_BIT];                          // [RULE_16]
    pe_m    = ctrl_reg[PE_MASK_BIT];
    of_m    = ctrl_reg[OF_MASK_BIT];
    rv_next   = op_valid;
    rd_next   = rd_reg;
    ruf_next  = 1'b0;
    rpe_next  = 1'b0;
    rof_next  = 1'b0;
    rexc_next = 1'b0;
    if (op_valid)
    begin
      if (uf_cond && !uf_m)
      begin
        // Trapped underflow: scaled result, underflow always
        rd_next   = op_double ? d_ufs : s_ufs;                // [RULE_06]
        ruf_next  = 1'b1;                                     // [RULE_07]
        rpe_next  = op_inexact;                               // [RULE_07]
        rexc_next = 1'b1;                                     // [RULE_16]
      end
      else if (of_cond && !of_m)
      begin
        // Trapped overflow: scaled down result
        rd_next   = op_double ? d_ofs : s_ofs;
        rof_next  = 1'b1;
        rpe_next  = op_inexact;
        rexc_next = 1'b1;
      end
      else if (uf_cond)
      begin
        // Masked underflow: bounded result, flags only if inexact
        rd_next   = op_bounded;                       // [RULE_04] [RULE_05]
        ruf_next  = op_bounded_inexact;               // [RULE_13]
        rpe_next  = op_bounded_inexact;               // [RULE_10]
        rexc_next = op_bounded_inexact && !pe_m;      // [RULE_11]
      end
      else if (of_cond)
      begin
        // Masked overflow: infinity or largest finite by rounding
        rd_next   = op_double ? d_ofm : s_ofm;        // [RULE_15] [RULE_12]
        rof_next  = 1'b1;                             // [RULE_12]
        rpe_next  = 1'b1;                             // [RULE_10]
        rexc_next = !pe_m;                            // [RULE_11]
      end
      else
      begin
        // No range problem: bounded rounded result
        rd_next   = is_int ? op_bounded
                  : (op_double ? d_plain : s_plain);  // [RULE_09] [RULE_14]
        rpe_next  = op_inexact;                       // [RULE_08]
        rexc_next = op_inexact && !pe_m;              // [RULE_11] [RULE_16]
      end
    end
  end

  // Result stage registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rv_reg   <= 1'b0;
      rd_reg   <= 64'h0;
      ruf_reg  <= 1'b0;
      rpe_reg  <= 1'b0;
      rof_reg  <= 1'b0;
      rexc_reg <= 1'b0;
    end
    else
    begin
      rv_reg   <= rv_next;
      rd_reg   <= rd_next;
      ruf_reg  <= ruf_next;
      rpe_reg  <= rpe_next;
      rof_reg  <= rof_next;
      rexc_reg <= rexc_next;
    end
  end

  // Bus slave and register file next state
  logic        wr_do, wr_hit, aw_take, w_take, ar_take;
  logic [31:0] bmask;
  logic [STAT_W-1:0] st_set, st_clr;
  always_comb
  begin
    aw_take = s_axi_awvalid && awready_reg;
    w_take  = s_axi_wvalid && wready_reg;
    ar_take = s_axi_arvalid && arready_reg;
    aw_got_next = aw_got_reg || aw_take;
    w_got_next  = w_got_reg || w_take;
    awaddr_next = aw_take ? s_axi_awaddr : awaddr_reg;
    wdata_next  = w_take ? s_axi_wdata : wdata_reg;
    wstrb_next  = w_take ? s_axi_wstrb : wstrb_reg;
    bmask = {{8{wstrb_reg[3]}}, {8{wstrb_reg[2]}},
             {8{wstrb_reg[1]}}, {8{wstrb_reg[0]}}};
    wr_do  = aw_got_reg && w_got_reg && !bvalid_reg;
    wr_hit = (awaddr_reg == CTRL_OFF) || (awaddr_reg == STATUS_OFF)
          || (awaddr_reg == IMASK_OFF);
    bvalid_next = bvalid_reg && !s_axi_bready;
    bresp_next  = bresp_reg;
    ctrl_next   = ctrl_reg;
    imask_next  = imask_reg;
    st_clr      = '0;
    if (wr_do)
    begin
      aw_got_next = 1'b0;
      w_got_next  = 1'b0;
      bvalid_next = 1'b1;
      bresp_next  = wr_hit ? RESP_OKAY : RESP_SLVERR;
      if (awaddr_reg == CTRL_OFF)
        ctrl_next = (ctrl_reg & ~bmask[CTRL_W-1:0])
                  | (wdata_reg[CTRL_W-1:0] & bmask[CTRL_W-1:0]);
      if (awaddr_reg == IMASK_OFF)
        imask_next = (imask_reg & ~bmask[STAT_W-1:0])
                   | (wdata_reg[STAT_W-1:0] & bmask[STAT_W-1:0]);
      if (awaddr_reg == STATUS_OFF)
        st_clr = wdata_reg[STAT_W-1:0] & bmask[STAT_W-1:0];
    end
    awready_next = !aw_got_next && !bvalid_next;
    wready_next  = !w_got_next && !bvalid_next;
    // Sticky flags: new events win over a same-cycle clear
    st_set = '0;
    st_set[UF_BIT]  = ruf_reg;
    st_set[PE_BIT]  = rpe_reg;
    st_set[OF_BIT]  = rof_reg;
    st_set[EXC_BIT] = rexc_reg;
    status_next = (status_reg & ~st_clr) | st_set;            // [RULE_17]
    irq_next    = |(status_next & imask_next);
    // Read channel: answer one cycle after address is taken
    rvalid_next = rvalid_reg && !s_axi_rready;
    rdata_next  = rdata_reg;
    rresp_next  = rresp_reg;
    if (ar_take)
    begin
      rvalid_next = 1'b1;
      rresp_next  = RESP_OKAY;
      case (s_axi_araddr)
        CTRL_OFF:   rdata_next = 32'(ctrl_reg);
        STATUS_OFF: rdata_next = 32'(status_reg);
        IMASK_OFF:  rdata_next = 32'(imask_reg);
        RES_LO_OFF: rdata_next = rd_reg[31:0];
        RES_HI_OFF: rdata_next = rd_reg[63:32];
        default:
        begin
          rdata_next = 32'h0;
          rresp_next = RESP_SLVERR;
        end
      endcase
    end
    arready_next = !rvalid_next;
  end

  // Bus slave and register file registers
  always_ff @(posedge ref_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ctrl_reg    <= CTRL_RESET;
      status_reg  <= STATUS_RESET;
      imask_reg   <= IMASK_RESET;
      irq_reg     <= 1'b0;
      aw_got_reg  <= 1'b0;
      w_got_reg   <= 1'b0;
      awaddr_reg  <= 8'h0;
      wdata_reg   <= 32'h0;
      wstrb_reg   <= 4'h0;
      awready_reg <= 1'b0;
      wready_reg  <= 1'b0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= 2'h0;
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0;
      rresp_reg   <= 2'h0;
    end
    else
    begin
      ctrl_reg    <= ctrl_next;
      status_reg  <= status_next;
      imask_reg   <= imask_next;
      irq_reg     <= irq_next;
      aw_got_reg  <= aw_got_next;
      w_got_reg   <= w_got_next;
      awaddr_reg  <= awaddr_next;
      wdata_reg   <= wdata_next;
      wstrb_reg   <= wstrb_next;
      awready_reg <= awready_next;
      wready_reg  <= wready_next;
      bvalid_reg  <= bvalid_next;
      bresp_reg   <= bresp_next;
      arready_reg <= arready_next;
      rvalid_reg  <= rvalid_next;
      rdata_reg   <= rdata_next;
      rresp_reg   <= rresp_next;
    end
  end

  // Outputs straight from flops
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign res_valid     = rv_reg;
  assign res_data      = rd_reg;
  assign res_underflow = ruf_reg;
  assign res_inexact   = rpe_reg;
  assign res_overflow  = rof_reg;
  assign fp_exception  = rexc_reg;
  assign irq           = irq_reg;

endmodule

// >>> tb/fpuir_monitor.sv
// Port checker for the underflow and inexact response unit.
// Assumes one clock, ref_clk, and the active-low asynchronous reset rstn.
`timescale 1ns/1ps
module fpuir_monitor
(
  input wire logic                    ref_clk,
  input wire logic                    rstn,
  input wire logic                    s_axi_awready,
  input wire logic                    op_valid,
  input wire fpuir_pkg::fpuir_op_type op_kind,
  input wire logic signed [15:0]      op_exp,
  input wire logic                    op_zero,
  input wire logic                    op_inexact,
  input wire logic                    op_bounded_inexact,
  input wire logic                    res_valid,
  input wire logic                    res_underflow,
  input wire logic                    res_inexact,
  input wire logic                    res_overflow,
  input wire logic                    fp_exception,
  input wire logic                    irq
);
  import fpuir_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  // Result strobe and a quiet result port
  sequence s_answer;
    res_valid;
  endsequence
  sequence s_quiet;
    !res_valid && !fp_exception;
  endsequence
  a_res_follows: assert property (op_valid |=> s_answer)
    else $error("result strobe missing after operation");
  a_no_stray: assert property (!op_valid |=> s_quiet)
    else $error("result without operation");
  a_flags_pulse: assert property (!res_valid |->
    !(res_underflow || res_inexact || res_overflow))
    else $error("flag outside result strobe");
  a_zero_calm: assert property (op_valid && op_zero |=>
    !res_underflow && !res_overflow)
    else $error("zero result flagged as tiny or huge");
  a_exact_calm: assert property (op_valid && !op_inexact &&
    !op_bounded_inexact && op_exp < 16'sd128 |=> !res_inexact)
    else $error("inexact flag on exact result");
  a_uf_tiny: assert property (op_valid && op_exp > -16'sd127 |=>
    !res_underflow)
    else $error("underflow flag on normal result");
  a_sqrt_no_uf: assert property (op_valid &&
    op_kind inside {OP_SQRT, OP_INT_CONV} |=> !res_underflow)
    else $error("underflow on square root or integer conversion");
  a_exc_cause: assert property (fp_exception |->
    res_underflow || res_inexact || res_overflow)
    else $error("exception without a flag");
  a_irq_sticky: assert property (irq && s_axi_awready |=> irq)
    else $error("interrupt dropped without a register write");
endmodule

// >>> tb/fpuir_top_test.sv
// Self-checking bench for the underflow and inexact response unit.
// Assumes the design package and top; binds the port checker below.
`timescale 1ns/1ps
module fpuir_top_test;
  import fpuir_pkg::*;
  // Expected result data and flags {exc, of, pe, uf}
  typedef struct {logic [63:0] d; logic [3:0] f;} fpuir_exp_type;
  logic               ref_clk, rstn, s_axi_awvalid, s_axi_wvalid;
  logic               s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic               s_axi_arready, s_axi_rvalid;
  logic [7:0]         s_axi_awaddr, s_axi_araddr;
  logic [31:0]        s_axi_wdata, s_axi_rdata;
  logic [3:0]         s_axi_wstrb;
  logic [1:0]         s_axi_bresp, s_axi_rresp;
  logic               op_valid, op_double, op_sign, op_zero, op_inexact;
  logic               op_bounded_inexact, res_valid, res_underflow;
  logic               res_inexact, res_overflow, fp_exception, irq;
  fpuir_op_type       op_kind;
  logic signed [15:0] op_exp;
  logic [51:0]        op_frac;
  logic [63:0]        op_bounded, res_data;
  fpuir_exp_type      expq[$];
  fpuir_exp_type      got;
  int                 failures = 0;
  int                 checks = 0;

  fpuir_top dut (.*);

  // Clock, 4 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task automatic test_done;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic chk(input logic [63:0] seen, exp, input string what);
    checks++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value at %0t ns: %s", $time, what);
    end
  endtask

  // Timeout exit
  task automatic tmo(input int n);
    if (n >= 200)
    begin
      chk(1, 0, "wait ran out");
      test_done;
    end
  endtask

  // Register write
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
                        input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end
    while (s_axi_bvalid !== 1'b1 && n < 200);
    chk(s_axi_bresp, er, "write response");
    s_axi_bready <= 1'b0;
    tmo(n);
  endtask

  // Register read
  task automatic axi_rd(input logic [7:0] a, input logic [31:0] ed,
                        input logic [1:0] er);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
      if (s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end
    while (s_axi_rvalid !== 1'b1 && n < 200);
    chk(s_axi_rdata, ed, "read data");
    chk(s_axi_rresp, er, "read response");
    s_axi_rready <= 1'b0;
    tmo(n);
  endtask

  // One operation, back to back
  task automatic op(input logic dbl, input fpuir_op_type k, input logic s,
    input int e, input logic [51:0] fr, input logic z, inx, bin,
    input logic [63:0] bnd, ed, input logic [3:0] ef);
    @(posedge ref_clk);
    op_valid <= 1'b1;
    op_double <= dbl;
    op_kind <= k;
    op_sign <= s;
    op_exp <= 16'(e);
    op_frac <= fr;
    op_zero <= z;
    op_inexact <= inx;
    op_bounded <= bnd;
    op_bounded_inexact <= bin;
    expq.push_back('{ed, ef});
  endtask

  task automatic idle;
    @(posedge ref_clk);
    op_valid <= 1'b0;
  endtask

  // Packed word
  function automatic logic [63:0] pk(input logic dbl, s, input int eb,
                                     input logic [51:0] fr);
    pk = dbl ? {s, 11'(eb), fr} : {32'h0, s, 8'(eb), fr[51:29]};
  endfunction

  // Result watcher
  always @(posedge ref_clk)
    if (res_valid === 1'b1)
    begin
      if (expq.size() == 0)
        chk(1, 0, "unexpected result");
      else
      begin
        got = expq.pop_front();
        chk(res_data, got.d, "result data");
        chk({fp_exception, res_overflow, res_inexact, res_underflow},
            {28'h0, got.f}, "result flags");
      end
    end

  initial
  begin
    logic [51:0] fr;
    logic [63:0] bnd;
    {rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, op_valid, op_double} = 4'h0;
    {op_sign, op_zero, op_inexact, op_bounded_inexact} = 4'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 52'h0;
    {op_exp, op_frac, op_bounded} = 132'h0;
    op_kind = OP_ADD;
    void'($urandom(32'h378a516e));
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (2) @(posedge ref_clk);
    axi_rd(CTRL_OFF, 32'(CTRL_RESET), RESP_OKAY);
    axi_rd(STATUS_OFF, 32'h0, RESP_OKAY);
    axi_rd(IMASK_OFF, 32'h0, RESP_OKAY);
    axi_rd(8'h14, 32'h0, RESP_SLVERR);
    axi_wr(8'h14, 32'hf, RESP_SLVERR);
    $display("test registers done");
    // All masked, back to back
    fr = 52'({$urandom, $urandom});
    bnd = {32'h0, $urandom};
    op(0, OP_ADD, 1, -127, fr, 0, 1, 1, bnd, {32'h0, bnd[31:0]}, 4'h3);
    op(0, OP_MUL, 0, -140, fr, 0, 0, 0, bnd, {32'h0, bnd[31:0]}, 4'h0);
    op(0, OP_NARROW, 0, -126, fr, 0, 0, 0, bnd, pk(0, 0, 1, fr), 4'h0);
    op(1, OP_DIV, 1, -1023, fr, 0, 1, 1, bnd, bnd, 4'h3);
    op(1, OP_SUB, 1, -1022, fr, 0, 0, 0, bnd, pk(1, 1, 1, fr), 4'h0);
    op(0, OP_HADD, 1, 128, fr, 0, 1, 0, bnd, 64'hff80_0000, 4'h6);
    op(1, OP_ADDSUB, 0, 1024, fr, 0, 1, 0, bnd, 64'h7ff0 << 48, 4'h6);
    op(0, OP_SUB, 0, 5, fr, 0, 1, 0, bnd, pk(0, 0, 132, fr), 4'h2);
    op(0, OP_ADD, 1, 0, 52'h0, 1, 0, 0, bnd, 64'h8000_0000, 4'h0);
    for (int k = 0; k < 10; k++)
      op(k[0], fpuir_op_type'(k), 0, 3, fr, 0, 0, 0, bnd, (k == 9) ? bnd :
         pk(k[0], 0, k[0] ? 1026 : 130, fr), 4'h0);
    idle;
    $display("test masked done");
    fr = 52'({$urandom, $urandom});
    axi_wr(CTRL_OFF, 32'h6, RESP_OKAY);
    op(0, OP_MUL, 1, -130, fr, 0, 1, 1, bnd, pk(0, 1, 189, fr), 4'hb);
    op(0, OP_NARROW, 0, -127, fr, 0, 0, 0, bnd, pk(0, 0, 192, fr), 4'h9);
    op(1, OP_DIV, 0, -1100, fr, 0, 1, 0, bnd, pk(1, 0, 1459, fr), 4'hb);
    idle;
    axi_wr(CTRL_OFF, 32'h5, RESP_OKAY);
    op(0, OP_ADD, 0, 10, fr, 0, 1, 0, bnd, pk(0, 0, 137, fr), 4'ha);
    op(0, OP_MUL, 0, 130, fr, 0, 1, 0, bnd, 64'h7f80_0000, 4'he);
    op(1, OP_SUB, 0, -1030, fr, 0, 1, 1, bnd, bnd, 4'hb);
    idle;
    axi_wr(CTRL_OFF, 32'h8, RESP_OKAY);
    op(0, OP_ADD, 0, -130, fr, 0, 1, 1, bnd, pk(0, 0, 189, fr), 4'hb);
    op(0, OP_DIV, 0, 200, fr, 0, 0, 0, bnd, pk(0, 0, 135, fr), 4'hc);
    idle;
    $display("test unmasked done");
    axi_wr(CTRL_OFF, 32'hf, RESP_OKAY);
    axi_wr(STATUS_OFF, 32'hf, RESP_OKAY);
    axi_rd(STATUS_OFF, 32'h0, RESP_OKAY);
    axi_wr(IMASK_OFF, 32'h1, RESP_OKAY);
    op(0, OP_MUL, 0, 130, fr, 0, 1, 0, bnd, 64'h7f7f_ffff, 4'h6);
    idle;
    repeat (4) @(posedge ref_clk);
    chk(irq, 0, "interrupt while disabled");
    op(0, OP_ADD, 1, -130, fr, 0, 1, 1, bnd, {32'h0, bnd[31:0]}, 4'h3);
    idle;
    repeat (4) @(posedge ref_clk);
    chk(irq, 1, "interrupt missing");
    axi_rd(STATUS_OFF, 32'h7, RESP_OKAY);
    axi_wr(STATUS_OFF, 32'h2, RESP_OKAY);
    axi_rd(STATUS_OFF, 32'h5, RESP_OKAY);
    axi_wr(STATUS_OFF, 32'h1, RESP_OKAY);
    repeat (2) @(posedge ref_clk);
    chk(irq, 0, "interrupt after clear");
    axi_rd(RES_LO_OFF, bnd[31:0], RESP_OKAY);
    $display("test sticky done");
    repeat (5) @(posedge ref_clk);
    chk(expq.size(), 0, "results missing");
    test_done;
  end
endmodule

bind fpuir_top fpuir_monitor mon (.*);
